// ===== common/rct_consts.vh
// Constants for the reload/capture timer control block
// Assumes an 8-bit register port and one 20 MHz system clock
`ifndef RCT_CONSTS_VH
`define RCT_CONSTS_VH
// ==========================================
// Register offsets
`define RCT_ADDR_W 8
`define RCT_OFF_CTRL 8'hC8
`define RCT_OFF_MODE 8'hC9
`define RCT_OFF_RCAP_LO 8'hCA
`define RCT_OFF_RCAP_HI 8'hCB
`define RCT_OFF_CNT_LO 8'hCC
`define RCT_OFF_CNT_HI 8'hCD
`define RCT_OFF_IRQ_STAT 8'hD0
`define RCT_OFF_IRQ_MASK 8'hD1
// ==========================================
// Control register fields
`define RCT_CTRL_OVF 7
`define RCT_CTRL_EXT 6
`define RCT_CTRL_RBAUD 5
`define RCT_CTRL_TBAUD 4
`define RCT_CTRL_TRIGEN 3
`define RCT_CTRL_RUN 2
`define RCT_CTRL_SRC 1
`define RCT_CTRL_CAP 0
`define RCT_CTRL_RST 8'h00
// ==========================================
// Mode register fields
`define RCT_MODE_OE 1
`define RCT_MODE_UPDN 0
`define RCT_MODE_RST 2'h0
`define RCT_MODE_RSVD_RD 6'h00
// ==========================================
// Interrupt status bits
`define RCT_IRQ_OVF 0
`define RCT_IRQ_EXT 1
`define RCT_IRQ_W 2
// ==========================================
// Timing
`define RCT_CLK_HZ 20000000
`define RCT_TIMER_DIV 6
`define RCT_DIV_LAST 3'h5
`define RCT_CNT_MAX 16'hFFFF
`endif

// ===== verilog/rct_edge.v
// Edge and level conditioner for a synchronous input pin
// Assumes the pin is already synchronous to the clock
`timescale 1ns/1ps
module rct_edge (
  input wire clk,
  input wire rst,
  input wire pin_in,
  output reg level_r,
  output wire fall,
  output wire rise
);
  reg prev_r;
  // ==========================================
  // Delay one cycle and compare
  always @(posedge clk) begin
    if (rst) begin
      prev_r <= 1'b1;
      level_r <= 1'b1;
    end else begin
      prev_r <= pin_in;
      level_r <= pin_in;
    end
  end
  assign fall = prev_r & ~pin_in;
  assign rise = ~prev_r & pin_in;
endmodule // rct_edge

// ===== verilog/rct_timer.v
// Reload/capture 16-bit timer with control, mode and interrupt registers
// Assumes an 8-bit register port, synchronous pins and a single clock
// Contract
// [RQ1] Enabled falling trigger edge causing capture or reload sets the external event flag.
// [RQ2] Set external event flag requests the timer interrupt when enabled.
// [RQ3] External event flag is only cleared by software writing zero.
// [RQ4] Source select low counts divided system clock; high counts count pin edges.
// [RQ5] Output enable drives count pin as generated clock; else pin is input.
// [RQ6] Mode bits 7..2 reserved; software must not write ones.
// [RQ7] Control register resets to zero; each bit individually writable.
// [RQ8] Mode output enable and up/down bits reset to zero; byte access only.
// [RQ9] Up/down enabled in reload mode: trigger pin high counts up, low down.
// [RQ10] Up overflow past FFFFh sets overflow flag, interrupts, loads reload value. Code: no flag while mode output enable set; 0000h loaded in capture mode.
// [RQ11] Down underflow at count equal reload sets overflow flag, loads FFFFh. Code sets no flag while mode output enable is set.
// [RQ12] Run bit enables counting of the low byte; clear stops counting. Code gates all 16 count bits.
// [RQ13] Capture select copies count on trigger edge; else reload; baud bits override.
// [RQ14] Overflow flag set only when no baud source bit is set.
`timescale 1ns/1ps
`include "rct_consts.vh"
module rct_timer (
  input wire CLK_SYS,
  input wire SYS_RST,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output reg [7:0] REG_RDATA,
  input wire COUNT_CLOCK_PIN_IN,
  output reg COUNT_CLOCK_PIN_OUT,
  output wire COUNT_CLOCK_PIN_OE,
  input wire EXTERNAL_TRIGGER_PIN,
  output wire BAUD_TICK,
  output wire RX_BAUD_SEL,
  output wire TX_BAUD_SEL,
  output wire IRQ
);
  // ==========================================
  // Registers
  reg [7:0] ctrl_r;
  reg [7:0] ctrl_nxt;
  reg [1:0] mode_r;
  reg [15:0] cnt_r;
  reg [15:0] cnt_nxt;
  reg [15:0] rcap_r;
  reg [15:0] rcap_nxt;
  reg [2:0] div_r;
  reg [`RCT_IRQ_W-1:0] stat_r;
  wire [`RCT_IRQ_W-1:0] stat_nxt;
  wire [`RCT_IRQ_W-1:0] stat_set;
  wire stat_clr_wr;
  reg [`RCT_IRQ_W-1:0] mask_r;
  reg clk_out_r;
  wire trig_level;
  wire trig_fall;
  wire pin_rise;
  wire pin_fall_unused;
  wire baud_mode;
  wire updn_mode;
  wire tick;
  wire up_wrap;
  wire dn_wrap;
  wire wrap;
  wire trig_act;
  wire do_capture;
  wire do_trig_reload;
  wire ovf_set;
  wire ext_set;
  wire wr_ctrl;
  wire wr_mode;
  // ==========================================
  // Pin conditioning
  rct_edge u_trig (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .pin_in(EXTERNAL_TRIGGER_PIN),
    .level_r(trig_level),
    .fall(trig_fall),
    .rise()
  );
  rct_edge u_cpin (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .pin_in(COUNT_CLOCK_PIN_IN),
    .level_r(pin_fall_unused),
    .fall(),
    .rise(pin_rise)
  );
  // ==========================================
  // Mode decode
  assign wr_ctrl = REG_WR & (REG_ADDR == `RCT_OFF_CTRL);
  assign wr_mode = REG_WR & (REG_ADDR == `RCT_OFF_MODE);
  assign baud_mode = ctrl_r[`RCT_CTRL_RBAUD] | ctrl_r[`RCT_CTRL_TBAUD];
  assign updn_mode = mode_r[`RCT_MODE_UPDN] & ~ctrl_r[`RCT_CTRL_CAP] & ~baud_mode; // RQ9
  // ==========================================
  // Count source
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      div_r <= 3'h0;
    end else if (div_r == `RCT_DIV_LAST) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end
  assign tick = ctrl_r[`RCT_CTRL_RUN] & // RQ12
    (ctrl_r[`RCT_CTRL_SRC] ? pin_rise : (div_r == 3'h0)); // RQ4
  // ==========================================
  // Wrap detection
  assign up_wrap = tick & (~updn_mode | trig_level) & (cnt_r == `RCT_CNT_MAX); // RQ10
  assign dn_wrap = tick & updn_mode & ~trig_level & (cnt_r == rcap_r); // RQ11
  assign wrap = up_wrap | dn_wrap;
  assign trig_act = trig_fall & ctrl_r[`RCT_CTRL_TRIGEN] & ~updn_mode;
  assign do_capture = trig_act & ctrl_r[`RCT_CTRL_CAP] & ~baud_mode; // RQ13
  assign do_trig_reload = trig_act & (~ctrl_r[`RCT_CTRL_CAP] | baud_mode); // RQ13
  assign ovf_set = wrap & ~baud_mode & ~mode_r[`RCT_MODE_OE]; // RQ14
  assign ext_set = do_capture | do_trig_reload; // RQ1
  assign BAUD_TICK = wrap & baud_mode;
  assign RX_BAUD_SEL = ctrl_r[`RCT_CTRL_RBAUD];
  assign TX_BAUD_SEL = ctrl_r[`RCT_CTRL_TBAUD];
  // ==========================================
  // Counter and reload/capture next state
  always @* begin
    cnt_nxt = cnt_r;
    rcap_nxt = rcap_r;
    if (up_wrap) begin
      cnt_nxt = ctrl_r[`RCT_CTRL_CAP] & ~baud_mode ? 16'h0000 : rcap_r; // RQ10
    end else if (dn_wrap) begin
      cnt_nxt = `RCT_CNT_MAX; // RQ11
    end else if (tick) begin
      cnt_nxt = (updn_mode & ~trig_level) ? cnt_r - 16'h0001 : cnt_r + 16'h0001; // RQ9
    end
    if (do_trig_reload) begin
      cnt_nxt = rcap_r; // RQ13
    end
    if (do_capture) begin
      rcap_nxt = cnt_r; // RQ13
    end
    if (REG_WR && REG_ADDR == `RCT_OFF_CNT_LO) begin
      cnt_nxt[7:0] = REG_WDATA;
    end
    if (REG_WR && REG_ADDR == `RCT_OFF_CNT_HI) begin
      cnt_nxt[15:8] = REG_WDATA;
    end
    if (REG_WR && REG_ADDR == `RCT_OFF_RCAP_LO) begin
      rcap_nxt[7:0] = REG_WDATA;
    end
    if (REG_WR && REG_ADDR == `RCT_OFF_RCAP_HI) begin
      rcap_nxt[15:8] = REG_WDATA;
    end
  end
  // ==========================================
  // Control register with hardware-set flags
  always @* begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = REG_WDATA; // RQ7
    end
    if (ovf_set) begin
      ctrl_nxt[`RCT_CTRL_OVF] = 1'b1;
    end
    if (ext_set) begin
      ctrl_nxt[`RCT_CTRL_EXT] = 1'b1; // RQ3
    end
  end
  // ==========================================
  // Interrupt status and mask
  assign stat_clr_wr = REG_WR & (REG_ADDR == `RCT_OFF_IRQ_STAT);
  assign stat_set[`RCT_IRQ_OVF] = ovf_set;
  assign stat_set[`RCT_IRQ_EXT] = ext_set;
  // Set wins over a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < `RCT_IRQ_W; gi = gi + 1) begin : g_stat
      assign stat_nxt[gi] = stat_set[gi] | (stat_r[gi] & ~(stat_clr_wr & REG_WDATA[gi]));
    end
  endgenerate
  assign IRQ = |(mask_r & stat_r) | (mask_r[`RCT_IRQ_EXT] & ctrl_r[`RCT_CTRL_EXT]) |
    (mask_r[`RCT_IRQ_OVF] & ctrl_r[`RCT_CTRL_OVF]); // RQ2
  // ==========================================
  // State registers
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ctrl_r <= `RCT_CTRL_RST; // RQ7
      mode_r <= `RCT_MODE_RST; // RQ8
      cnt_r <= 16'h0000;
      rcap_r <= 16'h0000;
      stat_r <= 2'h0;
      mask_r <= 2'h0;
      clk_out_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      cnt_r <= cnt_nxt;
      rcap_r <= rcap_nxt;
      stat_r <= stat_nxt;
      if (wr_mode) begin
        mode_r <= REG_WDATA[1:0]; // RQ8
      end
      if (REG_WR && REG_ADDR == `RCT_OFF_IRQ_MASK) begin
        mask_r <= REG_WDATA[`RCT_IRQ_W-1:0];
      end
      if (!mode_r[`RCT_MODE_OE]) begin
        clk_out_r <= 1'b0;
      end else if (up_wrap) begin
        clk_out_r <= ~clk_out_r;
      end
    end
  end
  // ==========================================
  // Shared count pin
  assign COUNT_CLOCK_PIN_OE = mode_r[`RCT_MODE_OE]; // RQ5
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      COUNT_CLOCK_PIN_OUT <= 1'b0;
    end else begin
      COUNT_CLOCK_PIN_OUT <= clk_out_r;
    end
  end
  // ==========================================
  // Read port
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `RCT_OFF_CTRL: REG_RDATA <= ctrl_r;
        `RCT_OFF_MODE: REG_RDATA <= {`RCT_MODE_RSVD_RD, mode_r}; // RQ6
        `RCT_OFF_RCAP_LO: REG_RDATA <= rcap_r[7:0];
        `RCT_OFF_RCAP_HI: REG_RDATA <= rcap_r[15:8];
        `RCT_OFF_CNT_LO: REG_RDATA <= cnt_r[7:0];
        `RCT_OFF_CNT_HI: REG_RDATA <= cnt_r[15:8];
        `RCT_OFF_IRQ_STAT: REG_RDATA <= {6'h00, stat_r};
        `RCT_OFF_IRQ_MASK: REG_RDATA <= {6'h00, mask_r};
        default: REG_RDATA <= 8'h00;
      endcase
    end else begin
      REG_RDATA <= 8'h00;
    end
  end
endmodule // rct_timer

// ===== testbench/rct_timer_properties.sv
// Checker for the timer register port and pins
// Assumes it is bound to rct_timer
`timescale 1ns/1ps
module rct_props (
  input wire CLK_SYS,
  input wire SYS_RST,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_RDATA,
  input wire COUNT_CLOCK_PIN_OUT,
  input wire COUNT_CLOCK_PIN_OE,
  input wire BAUD_TICK,
  input wire RX_BAUD_SEL,
  input wire TX_BAUD_SEL
);
  // ==========================================
  // Properties
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  sequence s_wr_ctrl; REG_WR && REG_ADDR == 8'hC8; endsequence
  sequence s_wr_mode; REG_WR && REG_ADDR == 8'hC9; endsequence
  sequence s_rd_mode; REG_RD && REG_ADDR == 8'hC9; endsequence
  property p_oe; s_wr_mode |=> COUNT_CLOCK_PIN_OE == $past(REG_WDATA[1]); endproperty
  a_oe: assert property (p_oe) else $error("pin enable not taken from write");
  property p_rx; s_wr_ctrl |=> RX_BAUD_SEL == $past(REG_WDATA[5]); endproperty
  a_rx: assert property (p_rx) else $error("receive select not taken");
  property p_tx; s_wr_ctrl |=> TX_BAUD_SEL == $past(REG_WDATA[4]); endproperty
  a_tx: assert property (p_tx) else $error("transmit select not taken");
  property p_rsvd; s_rd_mode |=> REG_RDATA[7:2] == 6'h00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved mode bits read set");
  property p_oerd; s_rd_mode |=> REG_RDATA[1] == COUNT_CLOCK_PIN_OE; endproperty
  a_oerd: assert property (p_oerd) else $error("mode read differs from pin enable");
  property p_idle; !REG_RD |=> REG_RDATA == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read cycle");
  property p_tick; BAUD_TICK |-> RX_BAUD_SEL || TX_BAUD_SEL; endproperty
  a_tick: assert property (p_tick) else $error("baud tick without baud source");
  property p_hold;
    !COUNT_CLOCK_PIN_OE && $past(!COUNT_CLOCK_PIN_OE) && $past(!COUNT_CLOCK_PIN_OE, 2) |=>
      $stable(COUNT_CLOCK_PIN_OUT);
  endproperty
  a_hold: assert property (p_hold) else $error("clock out moved while disabled");
endmodule // rct_props
bind rct_timer rct_props u_props (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .COUNT_CLOCK_PIN_OUT(COUNT_CLOCK_PIN_OUT), .COUNT_CLOCK_PIN_OE(COUNT_CLOCK_PIN_OE),
  .BAUD_TICK(BAUD_TICK), .RX_BAUD_SEL(RX_BAUD_SEL), .TX_BAUD_SEL(TX_BAUD_SEL));

// ===== testbench/testbench.sv
// Bench for the reload/capture timer block
// Assumes rct_timer with its checker bound
`timescale 1ns/1ps
module testbench;
  // ==========================================
  // Signals
  reg CLK_SYS = 1'b0;
  reg SYS_RST = 1'b1;
  reg [7:0] REG_ADDR = 8'h00;
  reg [7:0] REG_WDATA = 8'h00;
  reg REG_WR = 1'b0;
  reg REG_RD = 1'b0;
  reg PIN = 1'b0;
  reg TRIG = 1'b1;
  wire [7:0] REG_RDATA;
  wire OUT, OE, TICK, RXS, TXS, IRQ;
  reg [7:0] rv;
  reg [7:0] t;
  integer miscompares = 0;
  integer checked = 0;
  always #25 CLK_SYS = ~CLK_SYS;
  rct_timer u_dut (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .COUNT_CLOCK_PIN_IN(PIN),
    .COUNT_CLOCK_PIN_OUT(OUT), .COUNT_CLOCK_PIN_OE(OE), .EXTERNAL_TRIGGER_PIN(TRIG),
    .BAUD_TICK(TICK), .RX_BAUD_SEL(RXS), .TX_BAUD_SEL(TXS), .IRQ(IRQ));
  // ==========================================
  // Helpers
  task chk(input [7:0] s, input [7:0] e, input string n);
    begin
      checked = checked + 1;
      if (s !== e) begin
        miscompares = miscompares + 1;
        $display("wrong value %s expected %h seen %h", n, e, s);
      end
    end
  endtask
  task bus(input w, input r, input [7:0] a, input [7:0] d);
    begin
      REG_WR <= w;
      REG_RD <= r;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge CLK_SYS);
      #1;
    end
  endtask
  task nop(input integer n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      bus(1'b1, 1'b0, a, d);
      nop(1);
    end
  endtask
  task rd(input [7:0] a);
    begin
      bus(1'b0, 1'b1, a, 8'h00);
      rv = REG_RDATA;
      nop(1);
    end
  endtask
  task load(input [15:0] rc, input [15:0] c);
    begin
      wr(8'hCA, rc[7:0]);
      wr(8'hCB, rc[15:8]);
      wr(8'hCC, c[7:0]);
      wr(8'hCD, c[15:8]);
    end
  endtask
  // ==========================================
  // Scenarios
  task t_reset;
    begin
      rd(8'hC8);
      chk(rv, 8'h00, "control");
      rd(8'hC9);
      chk(rv, 8'h00, "mode");
      rd(8'h00);
      chk(rv, 8'h00, "unmapped");
      chk({7'h00, IRQ}, 8'h00, "irq");
    end
  endtask
  task t_mode;
    begin
      wr(8'hC9, 8'h03);
      rd(8'hC9);
      chk(rv, 8'h03, "mode");
      chk({7'h00, OE}, 8'h01, "oe");
      wr(8'hC9, 8'h00);
      chk({7'h00, OE}, 8'h00, "oe");
    end
  endtask
  task t_up;
    begin
      wr(8'hD1, 8'h03);
      load(16'hFFF0, 16'hFFFD);
      wr(8'hC8, 8'h04);
      nop(40);
      rd(8'hC8);
      chk(rv & 8'h80, 8'h80, "overflow");
      rd(8'hCD);
      chk(rv, 8'hFF, "count high");
      chk({7'h00, IRQ}, 8'h01, "irq");
      wr(8'hC8, 8'h00);
      rd(8'hCC);
      t = rv;
      nop(12);
      rd(8'hCC);
      chk(rv, t, "stopped");
      wr(8'hD0, 8'h03);
      chk({7'h00, IRQ}, 8'h00, "irq");
    end
  endtask
  task t_down;
    begin
      TRIG <= 1'b0;
      wr(8'hC9, 8'h01);
      load(16'h0010, 16'h0012);
      wr(8'hC8, 8'h04);
      nop(40);
      rd(8'hC8);
      chk(rv & 8'h80, 8'h80, "underflow");
      rd(8'hCD);
      chk(rv, 8'hFF, "count high");
      wr(8'hC8, 8'h00);
      wr(8'hC9, 8'h00);
      wr(8'hD0, 8'h03);
      TRIG <= 1'b1;
    end
  endtask
  task t_src;
    begin
      load(16'h0000, 16'h0000);
      wr(8'hC8, 8'h06);
      repeat (5) begin
        PIN <= 1'b1;
        nop(2);
        PIN <= 1'b0;
        nop(2);
      end
      wr(8'hC8, 8'h00);
      rd(8'hCC);
      chk(rv, 8'h05, "events");
    end
  endtask
  task t_ext;
    begin
      load(16'h1234, 16'h0000);
      wr(8'hC8, 8'h08);
      TRIG <= 1'b0;
      nop(4);
      rd(8'hC8);
      chk(rv & 8'h40, 8'h40, "event flag");
      rd(8'hCD);
      chk(rv, 8'h12, "reloaded");
      chk({7'h00, IRQ}, 8'h01, "irq");
      nop(20);
      rd(8'hC8);
      chk(rv & 8'h40, 8'h40, "event kept");
      wr(8'hC8, 8'h00);
      wr(8'hD0, 8'h03);
      chk({7'h00, IRQ}, 8'h00, "irq");
      TRIG <= 1'b1;
      load(16'h0000, 16'h5678);
      wr(8'hC8, 8'h09);
      TRIG <= 1'b0;
      nop(4);
      rd(8'hCB);
      chk(rv, 8'h56, "captured");
      rd(8'hC8);
      chk(rv & 8'h40, 8'h40, "capture flag");
      wr(8'hC8, 8'h00);
      wr(8'hD0, 8'h03);
      TRIG <= 1'b1;
    end
  endtask
  task t_baud;
    begin
      load(16'hFFF0, 16'hFFFD);
      wr(8'hC8, 8'h14);
      t = 8'h00;
      repeat (40) begin
        nop(1);
        if (TICK === 1'b1) t = t + 8'h01;
      end
      chk(t, 8'h01, "baud ticks");
      rd(8'hC8);
      chk(rv & 8'h80, 8'h00, "overflow");
      chk({7'h00, TXS}, 8'h01, "tx select");
      chk({7'h00, RXS}, 8'h00, "rx select");
      load(16'hFFF0, 16'hFFFD);
      wr(8'hC9, 8'h02);
      nop(40);
      chk({7'h00, OUT}, 8'h01, "clock out");
      wr(8'hC9, 8'h00);
      nop(3);
      chk({7'h00, OUT}, 8'h00, "clock out off");
      wr(8'hC8, 8'h00);
    end
  endtask
  task report_and_stop;
    begin
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial begin
    repeat (6) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    t_reset;
    $display("reset test done");
    t_mode;
    $display("mode test done");
    t_up;
    $display("up test done");
    t_down;
    $display("down test done");
    t_src;
    $display("source test done");
    t_ext;
    $display("trigger test done");
    t_baud;
    $display("baud test done");
    report_and_stop;
  end
  initial begin
    #1000000;
    miscompares = miscompares + 1;
    report_and_stop;
  end
endmodule // testbench
